// ==== pls_regs.vh ====
// Register map, field positions, reset values and encodings of the PHY status block
`ifndef PLS_REGS_VH
`define PLS_REGS_VH
// ----------------------------------------------------------------------
// Register offsets (chosen)
// ----------------------------------------------------------------------
`define PLS_ADDR_W 4
`define PLS_OFF_STAT1 4'h0
`define PLS_OFF_STAT2 4'h1
`define PLS_OFF_STAT3 4'h2
`define PLS_OFF_ADV 4'h3
`define PLS_OFF_IRQ_STAT 4'h4
`define PLS_OFF_IRQ_EN 4'h5
`define PLS_OFF_IRQ_CLR 4'h6
`define PLS_OFF_CTRL 4'h7
// ----------------------------------------------------------------------
// Status one fields
// ----------------------------------------------------------------------
`define PLS_S1_ABLE_MSB 14
`define PLS_S1_ABLE_LSB 11
`define PLS_S1_DONE 5
`define PLS_S1_RFAULT 4
`define PLS_S1_CAPABLE 3
`define PLS_S1_LINK 2
`define PLS_S1_EXT 0
// ----------------------------------------------------------------------
// Status two and three fields
// ----------------------------------------------------------------------
`define PLS_S2_POL 4
`define PLS_S2_FIXED 16'h000B
`define PLS_S3_MODE_MSB 4
`define PLS_S3_MODE_LSB 2
`define PLS_S3_FIXED 16'h0040
`define PLS_MODE_FAST_FULL 3'h6
`define PLS_MODE_SLOW_FULL 3'h5
`define PLS_MODE_FAST_HALF 3'h2
`define PLS_MODE_SLOW_HALF 3'h1
`define PLS_MODE_NONE 3'h0
`define PLS_MODE_FAST_BIT 1
`define PLS_S1_ABLE_ALL 4'hF
`define PLS_IRQ_NONE 3'h0
// ----------------------------------------------------------------------
// Advertisement fields
// ----------------------------------------------------------------------
`define PLS_ADV_FAULT 13
`define PLS_ADV_PAUSE_MSB 11
`define PLS_ADV_PAUSE_LSB 10
`define PLS_ADV_FF 8
`define PLS_ADV_FH 7
`define PLS_ADV_SF 6
`define PLS_ADV_SH 5
`define PLS_ADV_SEL_MSB 4
`define PLS_ADV_WMASK 16'h2DFF
`define PLS_ADV_RESET 16'h01E1
// ----------------------------------------------------------------------
// Interrupt and control fields
// ----------------------------------------------------------------------
`define PLS_IRQ_W 3
`define PLS_IRQ_DONE 0
`define PLS_IRQ_FAULT 1
`define PLS_IRQ_LINKDN 2
`define PLS_CTRL_NEG_EN 0
`define PLS_CTRL_RESTART 1
`define PLS_CTRL_RESET 16'h0001
`endif

// ==== pls_regs.v ====
// Status, advertisement and interrupt registers of a 10/100 PHY
`timescale 1ns/1ps
`include "pls_regs.vh"
//
// Summary of operation
// - Four fixed ability flags, bits 14..11 of status one, always read 1.
// - Negotiation-complete bit 5 reads 1 after negotiation finishes, else 0.
// - Remote-fault bit 4 latches high, clears after status one read.
// - Negotiation-capable bit 3 always reads 1.
// - Link bit 2 reads 1 only if link stayed up since last read.
// - Extended-registers bit 0 always reads 1.
// - Status two bit 4 shows reversed receive pair in 10 Mb/s mode.
// - Status three bits 4..2 encode resolved speed and duplex.
// - Advertisement bit 15, next page, reads 0.
// - Advertisement bit 13 is writable local fault, reset 0.
// - Advertisement bits 11..10 are writable pause mode.
// - Advertisement bits 8..5 writable abilities, reset 1.
// - Advertisement bits 14, 12, 9 read 0, not writable.
// - Advertisement word is sent to the partner during negotiation.
// - Mode resolves fast full, fast half, slow full, slow half.
// - Partner without negotiation: parallel detection, speed only, half duplex.
module pls_regs (
  input wire CLK,
  input wire SRST,
  input wire [3:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  input wire LINK_UP,
  input wire REMOTE_FAULT,
  input wire RECEIVE_PAIR_REVERSED,
  input wire PARTNER_VALID,
  input wire PARTNER_NEG_ABLE,
  input wire [15:0] PARTNER_WORD,
  input wire PARTNER_FAST,
  output reg [15:0] ADV_WORD,
  output reg ADV_SEND,
  output reg IRQ
);
  // ----------------------------------------------------------------------
  // Mode resolution
  // ----------------------------------------------------------------------
  function [2:0] resolve;
    input [15:0] loc;
    input [15:0] rem;
    reg [15:0] both;
    begin
      both = loc & rem;
      if (both[`PLS_ADV_FF])
        resolve = `PLS_MODE_FAST_FULL;
      else if (both[`PLS_ADV_FH])
        resolve = `PLS_MODE_FAST_HALF;
      else if (both[`PLS_ADV_SF])
        resolve = `PLS_MODE_SLOW_FULL;
      else if (both[`PLS_ADV_SH])
        resolve = `PLS_MODE_SLOW_HALF;
      else
        resolve = `PLS_MODE_NONE;
    end
  endfunction

  localparam ST_IDLE = 2'h0;
  localparam ST_NEG = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] adv_reg;
  reg [15:0] ctrl_reg;
  reg done_reg;
  reg [2:0] mode_reg;
  reg [2:0] mode_next;
  reg fault_reg;
  reg link_reg;
  reg pol_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_en_reg;
  reg link_prev_reg;
  reg [15:0] rdata_next;
  wire wr_adv = WR && (ADDR == `PLS_OFF_ADV);
  wire wr_ctrl = WR && (ADDR == `PLS_OFF_CTRL);
  wire rd_s1 = RD && (ADDR == `PLS_OFF_STAT1);
  wire restart = wr_ctrl && WDATA[`PLS_CTRL_RESTART];
  wire neg_en = ctrl_reg[`PLS_CTRL_NEG_EN];
  wire [2:0] events = {link_prev_reg & ~LINK_UP, REMOTE_FAULT, state_next == ST_DONE &&
    state_reg != ST_DONE};

  // ----------------------------------------------------------------------
  // Negotiation sequencer
  // ----------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    mode_next = mode_reg;
    case (state_reg)
      ST_IDLE: begin
        if (neg_en && !LINK_UP)
          state_next = ST_NEG;
      end
      ST_NEG: begin
        if (PARTNER_VALID) begin
          state_next = ST_DONE;
          if (!PARTNER_NEG_ABLE)
            mode_next = PARTNER_FAST ? `PLS_MODE_FAST_HALF : `PLS_MODE_SLOW_HALF;
          else
            mode_next = resolve(adv_reg, PARTNER_WORD);
        end
      end
      ST_DONE: begin
        if (!LINK_UP)
          state_next = ST_NEG;
      end
      default: state_next = ST_IDLE;
    endcase
    if (!neg_en)
      state_next = ST_IDLE;
    else if (restart)
      state_next = ST_NEG;
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always @* begin
    rdata_next = 16'h0000;
    case (ADDR)
      `PLS_OFF_STAT1: begin
        rdata_next[`PLS_S1_ABLE_MSB:`PLS_S1_ABLE_LSB] = `PLS_S1_ABLE_ALL;
        rdata_next[`PLS_S1_DONE] = done_reg;
        rdata_next[`PLS_S1_RFAULT] = fault_reg;
        rdata_next[`PLS_S1_CAPABLE] = 1'b1;
        rdata_next[`PLS_S1_LINK] = link_reg;
        rdata_next[`PLS_S1_EXT] = 1'b1;
      end
      `PLS_OFF_STAT2: begin
        rdata_next = `PLS_S2_FIXED;
        rdata_next[`PLS_S2_POL] = pol_reg;
      end
      `PLS_OFF_STAT3: begin
        rdata_next = `PLS_S3_FIXED;
        rdata_next[`PLS_S3_MODE_MSB:`PLS_S3_MODE_LSB] = mode_reg;
      end
      `PLS_OFF_ADV: rdata_next = adv_reg & `PLS_ADV_WMASK;
      `PLS_OFF_IRQ_STAT: rdata_next = {13'h0000, irq_stat_reg};
      `PLS_OFF_IRQ_EN: rdata_next = {13'h0000, irq_en_reg};
      `PLS_OFF_CTRL: rdata_next = ctrl_reg;
      default: rdata_next = 16'h0000;
    endcase
    if (!RD)
      rdata_next = 16'h0000;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always @(posedge CLK) begin
    if (SRST) begin
      state_reg <= ST_IDLE;
      adv_reg <= `PLS_ADV_RESET;
      ctrl_reg <= `PLS_CTRL_RESET;
      done_reg <= 1'b0;
      mode_reg <= `PLS_MODE_NONE;
      fault_reg <= 1'b0;
      link_reg <= 1'b0;
      pol_reg <= 1'b0;
      irq_stat_reg <= `PLS_IRQ_NONE;
      irq_en_reg <= `PLS_IRQ_NONE;
      link_prev_reg <= 1'b0;
      RDATA <= 16'h0000;
      ADV_WORD <= `PLS_ADV_RESET;
      ADV_SEND <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      done_reg <= (state_next == ST_DONE);
      link_prev_reg <= LINK_UP;
      RDATA <= rdata_next;
      if (wr_adv)
        adv_reg <= WDATA & `PLS_ADV_WMASK;
      if (wr_ctrl)
        ctrl_reg <= {15'h0000, WDATA[`PLS_CTRL_NEG_EN]};
      // Latch high, set wins over read clear
      fault_reg <= REMOTE_FAULT | (fault_reg & ~rd_s1);
      // Latch low, reload from live level on read
      link_reg <= rd_s1 ? LINK_UP : (link_reg & LINK_UP);
      // Polarity only meaningful at 10 Mb/s
      pol_reg <= RECEIVE_PAIR_REVERSED && !mode_reg[`PLS_MODE_FAST_BIT];
      // Set wins over clear
      irq_stat_reg <= events | (irq_stat_reg &
        ~((WR && ADDR == `PLS_OFF_IRQ_CLR) ? WDATA[`PLS_IRQ_W-1:0] : `PLS_IRQ_NONE));
      if (WR && ADDR == `PLS_OFF_IRQ_EN)
        irq_en_reg <= WDATA[`PLS_IRQ_W-1:0];
      IRQ <= |(irq_stat_reg & irq_en_reg);
      ADV_WORD <= adv_reg & `PLS_ADV_WMASK;
      ADV_SEND <= (state_reg == ST_NEG);
    end
  end
endmodule // pls_regs

// ==== pls_regs_sva.sv ====
// Port checks of the PHY status register block
`timescale 1ns/1ps
module pls_regs_sva (
  input wire CLK,
  input wire SRST,
  input wire [3:0] ADDR,
  input wire RD,
  input wire [15:0] RDATA,
  input wire LINK_UP,
  input wire REMOTE_FAULT,
  input wire [15:0] ADV_WORD
);
  // ------------------
  // Properties
  // ------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_rd1;
    RD && ADDR == 4'h0;
  endsequence
  property p_able; $past(RD) && $past(ADDR) == 4'h0 |-> RDATA[14:11] == 4'hF; endproperty
  a_able: assert property (p_able) else $error("ability low");
  property p_fix; $past(RD) && $past(ADDR) == 4'h0 |-> RDATA[3] && RDATA[0]; endproperty
  a_fix: assert property (p_fix) else $error("fixed low");
  property p_fset; REMOTE_FAULT ##1 s_rd1 |=> RDATA[4]; endproperty
  a_fset: assert property (p_fset) else $error("fault lost");
  property p_fclr; !REMOTE_FAULT throughout (s_rd1 ##3 s_rd1) |=> !RDATA[4]; endproperty
  a_fclr: assert property (p_fclr) else $error("fault stuck");
  property p_link; !LINK_UP ##1 s_rd1 |=> !RDATA[2]; endproperty
  a_link: assert property (p_link) else $error("link stuck");
  property p_mode; $past(RD) && $past(ADDR) == 4'h2 |-> !(RDATA[4:2] inside {3'h3, 3'h4, 3'h7});
  endproperty
  a_mode: assert property (p_mode) else $error("mode code");
  property p_rsv; (ADV_WORD & 16'hD200) == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("advert bits");
  property p_rst; $fell(SRST) |-> ADV_WORD == 16'h01E1; endproperty
  a_rst: assert property (p_rst) else $error("advert reset");
endmodule // pls_regs_sva
bind pls_regs pls_regs_sva pls_regs_sva_inst (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .RD(RD),
  .RDATA(RDATA), .LINK_UP(LINK_UP), .REMOTE_FAULT(REMOTE_FAULT), .ADV_WORD(ADV_WORD));

// ==== pls_partner.sv ====
// Remote link partner model
`timescale 1ns/1ps
module pls_partner (
  input wire clk,
  input wire adv_send,
  input wire [15:0] adv_word,
  input wire [3:0] abil,
  input wire [3:0] lag,
  output reg valid = 1'h0,
  output reg [15:0] word = 16'h0000,
  output reg [15:0] heard = 16'h0000
);
  // ------------------
  // Negotiation reply
  // ------------------
  reg [3:0] cnt_reg = 4'h0;
  always @(posedge clk) begin
    cnt_reg <= adv_send ? cnt_reg + 4'h1 : 4'h0;
    valid <= adv_send && cnt_reg >= lag;
    // Toggles between replies so stale data never looks valid
    word <= (adv_send && cnt_reg >= lag) ? {7'h00, abil, 5'h01} : ~word;
    if (adv_send)
      heard <= adv_word;
  end
endmodule // pls_partner

// ==== pls_regs_tb.sv ====
// Testbench of the PHY status register block
`timescale 1ns/1ps
module pls_regs_tb;
  // ------------------
  // Bench
  // ------------------
  reg clk = 1'h0, srst = 1'h1, wr_s = 1'h0, rd_s = 1'h0, lnk = 1'h0, rflt = 1'h0;
  reg rev = 1'h0, p_able = 1'h1, fst = 1'h0;
  reg [3:0] addr = 4'h0, p_abil = 4'hF;
  reg [15:0] wdata = 16'h0000;
  integer n_errors = 0, total_checks = 0, k;
  wire [15:0] rdata, adv_word, p_word, heard;
  wire adv_send, irq, p_valid;
  always #2.5 clk = ~clk;
  pls_regs pls_regs_inst (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .LINK_UP(lnk), .REMOTE_FAULT(rflt),
    .RECEIVE_PAIR_REVERSED(rev), .PARTNER_VALID(p_valid), .PARTNER_NEG_ABLE(p_able),
    .PARTNER_WORD(p_word), .PARTNER_FAST(fst), .ADV_WORD(adv_word), .ADV_SEND(adv_send),
    .IRQ(irq));
  pls_partner pls_partner_inst (.clk(clk), .adv_send(adv_send), .adv_word(adv_word),
    .abil(p_abil), .lag(p_abil | 4'h4), .valid(p_valid), .word(p_word), .heard(heard));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk);
      wr_s <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'h0;
    end
  endtask
  task rd(input [3:0] a, input [15:0] e);
    begin
      @(posedge clk);
      rd_s <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'h0;
      rflt <= 1'h0;
      #1 chk(rdata, e);
    end
  endtask
  task s1(input f, input l, input ef, input el);
    begin
      @(posedge clk);
      rflt <= f;
      lnk <= l;
      rd(4'h0, {11'h3C0, ef, 1'h1, el, 2'h1});
    end
  endtask
  task neg(input [3:0] ab, input b, input f, input [2:0] m);
    begin
      @(posedge clk);
      lnk <= 1'h0;
      p_abil <= ab;
      p_able <= b;
      fst <= f;
      wr(4'h7, 16'h0003);
      for (k = 0; k < 40 && adv_send !== 1'h1; k = k + 1) @(posedge clk);
      lnk <= 1'h1;
      for (k = 0; k < 40 && adv_send !== 1'h0; k = k + 1) @(posedge clk);
      rd(4'h2, {11'h002, m, 2'h0});
      rd(4'h1, {11'h000, ~m[1], 4'hB});
      rd(4'h0, 16'h7829);
      chk(heard, 16'h01E1);
    end
  endtask
  task conclude;
    begin
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    rd(4'h3, 16'h01E1);
    rd(4'h1, 16'h000B);
    rd(4'hF, 16'h0000);
    wr(4'h3, 16'hFFE1);
    rd(4'h3, 16'h2DE1);
    chk(adv_word, 16'h2DE1);
    for (k = 0; k < 4; k = k + 1) begin
      wr(4'h3, {4'h0, k[1:0], 10'h1E1});
      rd(4'h3, {4'h0, k[1:0], 10'h1E1});
    end
    wr(4'h3, 16'h01E1);
    rev <= 1'h1;
    neg(4'hF, 1'h1, 1'h0, 3'h6);
    neg(4'h6, 1'h1, 1'h0, 3'h2);
    neg(4'h3, 1'h1, 1'h1, 3'h5);
    neg(4'h1, 1'h1, 1'h1, 3'h1);
    neg(4'hF, 1'h0, 1'h1, 3'h2);
    neg(4'hF, 1'h0, 1'h0, 3'h1);
    wr(4'h7, 16'h0000);
    s1(1'h0, 1'h1, 1'h0, 1'h1);
    s1(1'h1, 1'h1, 1'h1, 1'h1);
    s1(1'h0, 1'h1, 1'h1, 1'h1);
    s1(1'h0, 1'h1, 1'h0, 1'h1);
    s1(1'h0, 1'h0, 1'h0, 1'h0);
    s1(1'h0, 1'h1, 1'h0, 1'h0);
    s1(1'h0, 1'h1, 1'h0, 1'h1);
    wr(4'h5, 16'h0002);
    rd(4'h4, 16'h0007);
    chk({15'h0000, irq}, 16'h0001);
    wr(4'h5, 16'h0000);
    rd(4'h5, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    wr(4'h6, 16'h0007);
    wr(4'h5, 16'h0007);
    rd(4'h4, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    s1(1'h1, 1'h1, 1'h1, 1'h1);
    rd(4'h4, 16'h0002);
    chk({15'h0000, irq}, 16'h0001);
    conclude;
  end
  initial begin
    #20000;
    n_errors = n_errors + 1;
    conclude;
  end
endmodule // pls_regs_tb
